// *** common/fpkd_defs.vh ***
// Constants for the front-panel key and display controller.
`ifndef FPKD_DEFS_VH
`define FPKD_DEFS_VH
`define FPKD_CLK_MHZ 50
`define FPKD_TICK_US 1000
`define FPKD_TICK_CYC (`FPKD_TICK_US * `FPKD_CLK_MHZ)
`define FPKD_DEB_MS 10
`define FPKD_HOLD_FAST_MS 500
`define FPKD_HOLD_VFAST_MS 2000
`define FPKD_FAST_PER_MS 7'h64
`define FPKD_VFAST_PER_MS 7'h14
`define FPKD_FLASH_MS 12'h7D0
`define FPKD_BANNER_MS 2000
`define FPKD_BLINK_MS 250
`define FPKD_ACT_PAGES 4'h7
`define FPKD_SP_PAGES 4'h8
`define FPKD_DEF_PAGE 4'h1
`define FPKD_DEF_LINE 4'h3
`define FPKD_K_VUP 0
`define FPKD_K_VDN 1
`define FPKD_K_PGUP 2
`define FPKD_K_PGDN 3
`define FPKD_K_LNUP 4
`define FPKD_K_LNDN 5
`define FPKD_K_STORE 6
`define FPKD_K_CLEAR 7
`define FPKD_K_RESET 8
`define FPKD_K_HELP 9
`define FPKD_K_ACT 10
`define FPKD_K_SETP 11
`define FPKD_FL_NONE 3'h0
`define FPKD_FL_STORED 3'h1
`define FPKD_FL_ACCESS 3'h2
`define FPKD_FL_COMM 3'h3
`define FPKD_FL_COND 3'h4
`define FPKD_A_STATUS 5'h00
`define FPKD_A_SPSEL 5'h04
`define FPKD_A_SPDATA 5'h08
`define FPKD_A_LIMIT 5'h0C
`define FPKD_LIMIT_RST 16'h03E7
`define FPKD_RESP_OKAY 2'h0
`define FPKD_RESP_SLVERR 2'h2
`endif

// *** src/fpkd_top.v ***
// Front-panel keypad, display mode and indicator controller with an AXI4-Lite register slave.
// How it works
// - Value key held over half a second repeats the setpoint step at fast rate.
// - Value key held over two seconds repeats at a very fast rate.
// - Up key increments, down key decrements; either toggles a yes/no answer.
// - Stored value stays in force until the store key commits the edit.
// - Value keys act only on a shown setpoint or an actual-view question.
// - Reset key releases latched outputs; any held back flashes a condition message.
// - A latched output is kept while its causing condition persists.
// - Emergency restart input shorted forces remaining lockout time to zero.
// - Clear key in setpoint mode discards an unstored edit, else does nothing.
// - Clear key in help returns to the saved mode, page and line.
// - Clear key is ignored outside setpoint and help modes.
// - Store key in setpoint mode writes memory, takes effect, flashes stored.
// - Yes on clear-last-access question plus store clears maximum temperatures.
// - Yes on start-commissioning question plus store clears statistics.
// - Store key is ignored unless the access terminals are shorted.
// - Four indicators follow trip, alarm, aux one and aux two outputs.
// - Exactly one of four display modes; protection is independent of it.
// - Fault mode on threshold exceeded, others by their keys; clear in help also returns to any saved mode, fault included.
// - Pages and lines navigate view and edit modes; help and fault use lines.
// - Power-up banner first, then the phase current line of page one.
// - Line down on last line and line up on first line keep the line but drop an unstored edit and the answer.
`include "fpkd_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module fpkd_top #(
    parameter [15:0] TICK_CYC = `FPKD_TICK_CYC
) (
    input wire aclk,
    input wire aresetn,
    input wire [11:0] keys,
    input wire access_pin,
    input wire emerg_pin,
    input wire [3:0] out_set,
    input wire [3:0] out_cond,
    input wire thresh_exceeded,
    input wire selftest_fail,
    input wire low_supply,
    input wire [7:0] lockout_min_in,
    input wire sp_shown,
    input wire q_shown,
    input wire q_kind,
    input wire [3:0] last_line,
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [3:0] relay_r,
    output reg [3:0] led_r,
    output reg service_led_r,
    output reg [1:0] mode_r,
    output reg [3:0] page_r,
    output reg [3:0] line_r,
    output reg [15:0] disp_value_r,
    output reg answer_r,
    output reg banner_r,
    output reg [2:0] flash_code_r,
    output reg clr_maxtemp_r,
    output reg clr_stats_r,
    output reg [7:0] lockout_min_r,
    output reg [15:0] sp_active_r
);
    localparam [1:0] M_ACT = 2'h0;
    localparam [1:0] M_SETP = 2'h1;
    localparam [1:0] M_HELP = 2'h2;
    localparam [1:0] M_FAULT = 2'h3;

    // Setpoint memory index from page and line.
    function [5:0] sp_idx;
        input [3:0] pg;
        input [3:0] ln;
        begin
            sp_idx = {pg[2:0], ln[2:0]};
        end
    endfunction

    // One step up or down, held inside zero and the limit.
    function [15:0] step;
        input [15:0] v;
        input up;
        input [15:0] lim;
        begin
            if (up)
                step = (v >= lim) ? lim : v + 16'h0001;
            else
                step = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
        end
    endfunction

    // Byte-lane merge of a 16-bit register.
    function [15:0] wmerge;
        input [15:0] old;
        input [31:0] d;
        input [3:0] s;
        begin
            wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
        end
    endfunction

    reg [15:0] sp_mem [0:63];
    reg [11:0] key_s1_r, key_s2_r, deb_r, deb_q_r;
    reg [1:0] pin_s1_r, pin_s2_r;
    reg [15:0] tick_cnt_r;
    reg tick_r;
    reg [3:0] deb_cnt_r;
    reg [11:0] hold_r;
    reg [6:0] rep_r;
    reg rep_fire_r;
    reg [11:0] ban_cnt_r, fl_cnt_r;
    reg [7:0] blink_cnt_r;
    reg blink_r, thr_q_r, edited_r;
    reg [15:0] edit_r, limit_r;
    reg [5:0] sel_r;
    reg [1:0] sv_mode_r;
    reg [3:0] sv_page_r, sv_line_r, latch_r;
    reg aw_hold_r, w_hold_r;
    reg [4:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg [31:0] rd_mux;
    reg rd_ok;
    wire [11:0] press = deb_r & ~deb_q_r;
    wire val_held = deb_r[`FPKD_K_VUP] | deb_r[`FPKD_K_VDN];
    wire val_ev = press[`FPKD_K_VUP] | press[`FPKD_K_VDN] | rep_fire_r;
    wire val_up = deb_r[`FPKD_K_VUP];
    wire access_ok = pin_s2_r[0];
    wire [5:0] cur_idx = sp_idx(page_r, line_r);
    wire [15:0] cur_sp = sp_mem[cur_idx];
    wire [3:0] npages = (mode_r == M_ACT) ? `FPKD_ACT_PAGES : `FPKD_SP_PAGES;
    wire book = (mode_r == M_ACT) || (mode_r == M_SETP);
    wire [6:0] rep_per = (hold_r >= `FPKD_HOLD_VFAST_MS) ? `FPKD_VFAST_PER_MS : `FPKD_FAST_PER_MS;

    // Register read decode.
    always @*
    begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `FPKD_A_STATUS: rd_mux = {10'h000, answer_r, edited_r, flash_code_r, banner_r,
                                      latch_r, line_r, page_r, 2'h0, mode_r};
            `FPKD_A_SPSEL: rd_mux = {26'h0000000, sel_r};
            `FPKD_A_SPDATA: rd_mux = {16'h0000, sp_mem[sel_r]};
            `FPKD_A_LIMIT: rd_mux = {16'h0000, limit_r};
            default: rd_ok = 1'b0;
        endcase
    end

    // Pin synchronisers, millisecond tick and key debounce.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            key_s1_r <= 12'h000;
            key_s2_r <= 12'h000;
            pin_s1_r <= 2'h0;
            pin_s2_r <= 2'h0;
            tick_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
            deb_cnt_r <= 4'h0;
            deb_r <= 12'h000;
            deb_q_r <= 12'h000;
            hold_r <= 12'h000;
            rep_r <= 7'h00;
            rep_fire_r <= 1'b0;
        end
        else
        begin
            key_s1_r <= keys;
            key_s2_r <= key_s1_r;
            pin_s1_r <= {emerg_pin, access_pin};
            pin_s2_r <= pin_s1_r;
            tick_r <= (tick_cnt_r == TICK_CYC - 16'h0001);
            tick_cnt_r <= (tick_cnt_r == TICK_CYC - 16'h0001) ? 16'h0000 : tick_cnt_r + 16'h0001;
            deb_q_r <= deb_r;
            rep_fire_r <= 1'b0;
            if (tick_r)
            begin
                if (deb_cnt_r == `FPKD_DEB_MS - 1)
                begin
                    deb_cnt_r <= 4'h0;
                    deb_r <= key_s2_r;
                end
                else
                    deb_cnt_r <= deb_cnt_r + 4'h1;
                if (!val_held)
                begin
                    hold_r <= 12'h000;
                    rep_r <= 7'h00;
                end
                else
                begin
                    if (hold_r != 12'hFFF)
                        hold_r <= hold_r + 12'h001;
                    if (hold_r > `FPKD_HOLD_FAST_MS)
                    begin
                        if (rep_r >= rep_per - 7'h01)
                        begin
                            rep_r <= 7'h00;
                            rep_fire_r <= 1'b1;
                        end
                        else
                            rep_r <= rep_r + 7'h01;
                    end
                end
            end
        end
    end

    // Display modes, key actions, latched outputs and register slave.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_r <= M_ACT;
            page_r <= `FPKD_DEF_PAGE;
            line_r <= `FPKD_DEF_LINE;
            sv_mode_r <= M_ACT;
            sv_page_r <= 4'h1;
            sv_line_r <= 4'h1;
            banner_r <= 1'b1;
            ban_cnt_r <= 12'h000;
            fl_cnt_r <= 12'h000;
            flash_code_r <= `FPKD_FL_NONE;
            blink_cnt_r <= 8'h00;
            blink_r <= 1'b0;
            service_led_r <= 1'b1;
            thr_q_r <= 1'b0;
            edited_r <= 1'b0;
            edit_r <= 16'h0000;
            answer_r <= 1'b0;
            latch_r <= 4'h0;
            relay_r <= 4'h0;
            led_r <= 4'h0;
            clr_maxtemp_r <= 1'b0;
            clr_stats_r <= 1'b0;
            lockout_min_r <= 8'h00;
            disp_value_r <= 16'h0000;
            sp_active_r <= 16'h0000;
            limit_r <= `FPKD_LIMIT_RST;
            sel_r <= 6'h00;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 5'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FPKD_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `FPKD_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end
        else
        begin
            clr_maxtemp_r <= 1'b0;
            clr_stats_r <= 1'b0;
            thr_q_r <= thresh_exceeded;
            lockout_min_r <= pin_s2_r[1] ? 8'h00 : lockout_min_in;
            // Timers on the millisecond tick.
            if (tick_r)
            begin
                if (banner_r)
                begin
                    ban_cnt_r <= ban_cnt_r + 12'h001;
                    if (ban_cnt_r == `FPKD_BANNER_MS - 1)
                        banner_r <= 1'b0;
                end
                if (fl_cnt_r != 12'h000)
                begin
                    fl_cnt_r <= fl_cnt_r - 12'h001;
                    if (fl_cnt_r == 12'h001)
                        flash_code_r <= `FPKD_FL_NONE;
                end
                if (blink_cnt_r == `FPKD_BLINK_MS - 1)
                begin
                    blink_cnt_r <= 8'h00;
                    blink_r <= ~blink_r;
                end
                else
                    blink_cnt_r <= blink_cnt_r + 8'h01;
            end
            service_led_r <= selftest_fail ? blink_r : (low_supply | banner_r);
            // Register slave, write side.
            s_axi_awready <= !aw_hold_r && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_hold_r && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (aw_hold_r && w_hold_r && !s_axi_bvalid)
            begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `FPKD_RESP_OKAY;
                case (awaddr_r)
                    `FPKD_A_STATUS: s_axi_bresp <= `FPKD_RESP_OKAY;
                    `FPKD_A_SPSEL:
                        if (wstrb_r[0])
                            sel_r <= wdata_r[5:0];
                    `FPKD_A_SPDATA: sp_mem[sel_r] <= wmerge(sp_mem[sel_r], wdata_r, wstrb_r);
                    `FPKD_A_LIMIT: limit_r <= wmerge(limit_r, wdata_r, wstrb_r);
                    default: s_axi_bresp <= `FPKD_RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            // Register slave, read side.
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? `FPKD_RESP_OKAY : `FPKD_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            // Latched outputs: a new event wins over a reset key in the same cycle.
            if (press[`FPKD_K_RESET])
            begin
                latch_r <= (latch_r & out_cond) | out_set;
                if ((latch_r & out_cond) != 4'h0)
                begin
                    flash_code_r <= `FPKD_FL_COND;
                    fl_cnt_r <= `FPKD_FLASH_MS;
                end
            end
            else
                latch_r <= latch_r | out_set;
            relay_r <= latch_r;
            led_r <= latch_r;
            // Display mode selection; protection logic above never looks at it.
            if (thresh_exceeded && !thr_q_r)
            begin
                mode_r <= M_FAULT;
                line_r <= 4'h1;
                edited_r <= 1'b0;
                answer_r <= 1'b0;
            end
            else if (press[`FPKD_K_ACT] || press[`FPKD_K_SETP])
            begin
                mode_r <= press[`FPKD_K_ACT] ? M_ACT : M_SETP;
                page_r <= 4'h1;
                line_r <= 4'h1;
                edited_r <= 1'b0;
                answer_r <= 1'b0;
            end
            else if (press[`FPKD_K_HELP] && mode_r != M_HELP && flash_code_r == `FPKD_FL_NONE)
            begin
                sv_mode_r <= mode_r;
                sv_page_r <= page_r;
                sv_line_r <= line_r;
                mode_r <= M_HELP;
                line_r <= 4'h1;
            end
            else if (press[`FPKD_K_CLEAR])
            begin
                if (mode_r == M_HELP)
                begin
                    mode_r <= sv_mode_r;
                    page_r <= sv_page_r;
                    line_r <= sv_line_r;
                end
                else if (mode_r == M_SETP && edited_r)
                begin
                    edited_r <= 1'b0;
                    edit_r <= cur_sp;
                end
            end
            else if ((press[`FPKD_K_PGUP] || press[`FPKD_K_PGDN]) && book)
            begin
                if (press[`FPKD_K_PGDN] && page_r < npages)
                    page_r <= page_r + 4'h1;
                else if (press[`FPKD_K_PGUP] && page_r > 4'h1)
                    page_r <= page_r - 4'h1;
                line_r <= 4'h1;
                edited_r <= 1'b0;
                answer_r <= 1'b0;
            end
            else if (press[`FPKD_K_LNDN] || press[`FPKD_K_LNUP])
            begin
                if (press[`FPKD_K_LNDN] && line_r < last_line)
                    line_r <= line_r + 4'h1;
                else if (press[`FPKD_K_LNUP] && line_r > 4'h1)
                    line_r <= line_r - 4'h1;
                edited_r <= 1'b0;
                answer_r <= 1'b0;
            end
            else if (val_ev)
            begin
                if (mode_r == M_SETP && sp_shown)
                begin
                    edit_r <= step(edited_r ? edit_r : cur_sp, val_up, limit_r);
                    edited_r <= 1'b1;
                end
                else if (mode_r == M_ACT && q_shown && !rep_fire_r)
                    answer_r <= ~answer_r;
            end
            else if (press[`FPKD_K_STORE] && access_ok)
            begin
                if (mode_r == M_SETP && sp_shown && edited_r)
                begin
                    sp_mem[cur_idx] <= edit_r;
                    edited_r <= 1'b0;
                    flash_code_r <= `FPKD_FL_STORED;
                    fl_cnt_r <= `FPKD_FLASH_MS;
                end
                else if (mode_r == M_ACT && q_shown && answer_r)
                begin
                    clr_maxtemp_r <= !q_kind;
                    clr_stats_r <= q_kind;
                    flash_code_r <= q_kind ? `FPKD_FL_COMM : `FPKD_FL_ACCESS;
                    fl_cnt_r <= `FPKD_FLASH_MS;
                    answer_r <= 1'b0;
                end
            end
            disp_value_r <= edited_r ? edit_r : cur_sp;
            sp_active_r <= cur_sp;
        end
    end
endmodule // fpkd_top
`default_nettype wire

// *** test/fpkd_properties.sv ***
// Concurrent checks on the front-panel controller ports.
`timescale 1ns/1ps
`default_nettype none
module fpkd_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic emerg_pin,
    input wire logic thresh_exceeded,
    input wire logic selftest_fail,
    input wire logic low_supply,
    input wire logic [3:0] out_cond,
    input wire logic [3:0] last_line,
    input wire logic [3:0] relay_r,
    input wire logic [3:0] led_r,
    input wire logic service_led_r,
    input wire logic [1:0] mode_r,
    input wire logic [3:0] page_r,
    input wire logic [3:0] line_r,
    input wire logic banner_r,
    input wire logic clr_maxtemp_r,
    input wire logic clr_stats_r,
    input wire logic [7:0] lockout_min_r
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_led;
        led_r == relay_r;
    endproperty
    a_led: assert property (p_led) else $error("indicator mismatch");
    property p_keep;
        (relay_r & $past(relay_r) & $past(out_cond, 2)) == ($past(relay_r) & $past(out_cond, 2));
    endproperty
    a_keep: assert property (p_keep) else $error("held output dropped");
    property p_lock;
        emerg_pin [*4] |=> lockout_min_r == 8'h00;
    endproperty
    a_lock: assert property (p_lock) else $error("lockout not zero");
    property p_low;
        (low_supply && !selftest_fail) [*2] |-> service_led_r;
    endproperty
    a_low: assert property (p_low) else $error("service light off");
    property p_fault;
        $rose(mode_r == 2'h3) |-> $past(thresh_exceeded) || $past(thresh_exceeded, 2);
    endproperty
    a_fault: assert property (p_fault) else $error("fault mode without cause");
    property p_home;
        $fell(banner_r) |-> mode_r == 2'h0 && page_r == 4'h1 && line_r == 4'h3;
    endproperty
    a_home: assert property (p_home) else $error("wrong first view");
    property p_line;
        $stable(mode_r) && $stable(page_r) && $past(line_r) == $past(last_line) |-> line_r <= $past(line_r);
    endproperty
    a_line: assert property (p_line) else $error("moved past last line");
    property p_clr;
        clr_maxtemp_r |-> !clr_stats_r ##1 !clr_maxtemp_r;
    endproperty
    a_clr: assert property (p_clr) else $error("clear pulse wrong");
    c_fault: cover property (mode_r == 2'h3);
    c_stats: cover property (clr_stats_r);
    c_home: cover property ($fell(banner_r));
endmodule // fpkd_properties
bind fpkd_top fpkd_properties chk_u (.aclk, .aresetn, .emerg_pin, .thresh_exceeded, .selftest_fail,
    .low_supply, .out_cond, .last_line, .relay_r, .led_r, .service_led_r, .mode_r, .page_r, .line_r,
    .banner_r, .clr_maxtemp_r, .clr_stats_r, .lockout_min_r);
`default_nettype wire

// *** test/fpkd_operator.sv ***
// Operator model that presses front-panel keys with contact bounce.
`timescale 1ns/1ps
`default_nettype none
module fpkd_operator #(
    parameter int TICK = 5
) (
    input wire logic aclk,
    output logic [11:0] keys
);
    initial keys = 12'h000;
    // Bounces, holds for ms, releases and settles.
    task automatic press(input int k, input int ms);
        for (int i = 0; i < 3; i++)
        begin
            repeat (2) @(posedge aclk);
            keys[k] <= ~keys[k];
        end
        repeat (ms * TICK) @(posedge aclk);
        keys[k] <= 1'b0;
        repeat (40 * TICK) @(posedge aclk);
    endtask
endmodule // fpkd_operator
`default_nettype wire

// *** test/tb_top.sv ***
// Testbench for the front-panel controller.
`include "fpkd_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int TK = 5;
    logic aclk, aresetn, access_pin, emerg_pin, thresh_exceeded, selftest_fail, low_supply, sp_shown, q_shown, q_kind;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pv;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic service_led_r, answer_r, banner_r, clr_maxtemp_r, clr_stats_r;
    logic [1:0] s_axi_bresp, s_axi_rresp, mode_r;
    logic [2:0] flash_code_r;
    logic [3:0] out_set, out_cond, last_line, s_axi_wstrb, relay_r, led_r, page_r, line_r;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [7:0] lockout_min_in, lockout_min_r, lk;
    logic [11:0] keys;
    logic [15:0] disp_value_r, sp_active_r;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [33:0] exp_q[$];
    int fails = 0, n_compared = 0, n_mt = 0, n_st = 0, tog;
    fpkd_top #(.TICK_CYC(16'h0005)) dut_u (.*);
    fpkd_operator #(.TICK(TK)) op_u (.aclk(aclk), .keys(keys));
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (fails == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic kp(input int k, input int n);
        repeat (n) op_u.press(k, 30);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_p = 1'b1, w_p = 1'b1;
        exp_q.push_back({r, 32'h00000000});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_p || w_p)
        begin
            @(posedge aclk);
            aw_p = aw_p && !s_axi_awready;
            w_p = w_p && !s_axi_wready;
            s_axi_awvalid <= aw_p;
            s_axi_wvalid <= w_p;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    // Pairs bus answers with queued notes.
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            check({s_axi_bresp, 32'h00000000}, exp_q.pop_front());
        if (clr_maxtemp_r)
            n_mt++;
        if (clr_stats_r)
            n_st++;
    end
    initial
    begin
        repeat (90000) @(posedge aclk);
        fails++;
        close_out();
    end
    initial
    begin
        void'($urandom(63));
        {aresetn, access_pin, emerg_pin, thresh_exceeded, selftest_fail, low_supply} = 6'h00;
        {sp_shown, q_shown, q_kind, out_set, out_cond, lockout_min_in} = 19'h00000;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h00000000000;
        s_axi_wstrb = 4'hF;
        last_line = 4'h3;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        check(service_led_r, 1'b1);
        rd(`FPKD_A_STATUS, 34'h00010310);
        repeat (2100 * TK) @(posedge aclk);
        rd(`FPKD_A_STATUS, 34'h00000310);
        kp(`FPKD_K_CLEAR, 1);
        rd(`FPKD_A_STATUS, 34'h00000310);
        kp(`FPKD_K_HELP, 1);
        check(mode_r, 2'h2);
        kp(`FPKD_K_LNDN, 1);
        kp(`FPKD_K_CLEAR, 1);
        rd(`FPKD_A_STATUS, 34'h00000310);
        thresh_exceeded <= 1'b1;
        repeat (10) @(posedge aclk);
        check(mode_r, 2'h3);
        thresh_exceeded <= 1'b0;
        kp(`FPKD_K_ACT, 1);
        check(mode_r, 2'h0);
        rd(`FPKD_A_LIMIT, 34'h000003E7);
        rd(5'h10, {`FPKD_RESP_SLVERR, 32'h00000000});
        wr(`FPKD_A_STATUS, 32'hFFFFFFFF, `FPKD_RESP_OKAY);
        wr(`FPKD_A_SPSEL, 32'h0000000B, `FPKD_RESP_OKAY);
        wr(`FPKD_A_SPDATA, 32'h00000064, `FPKD_RESP_OKAY);
        kp(`FPKD_K_SETP, 1);
        kp(`FPKD_K_PGUP, 7);
        kp(`FPKD_K_PGDN, 1);
        kp(`FPKD_K_PGUP, 1);
        kp(`FPKD_K_LNUP, 1);
        kp(`FPKD_K_LNDN, 3);
        rd(`FPKD_A_STATUS, 34'h00000311);
        check(sp_active_r, 16'h0064);
        kp(`FPKD_K_VUP, 1);
        check(disp_value_r, 16'h0064);
        sp_shown <= 1'b1;
        kp(`FPKD_K_VUP, 1);
        check(disp_value_r, 16'h0065);
        check(sp_active_r, 16'h0064);
        rd(`FPKD_A_SPDATA, 34'h00000064);
        kp(`FPKD_K_VDN, 1);
        check(disp_value_r, 16'h0064);
        kp(`FPKD_K_VUP, 1);
        kp(`FPKD_K_CLEAR, 1);
        check(disp_value_r, 16'h0064);
        kp(`FPKD_K_VUP, 1);
        kp(`FPKD_K_STORE, 1);
        check(sp_active_r, 16'h0064);
        access_pin <= 1'b1;
        kp(`FPKD_K_STORE, 1);
        check(sp_active_r, 16'h0065);
        rd(`FPKD_A_STATUS, 34'h00020311);
        rd(`FPKD_A_SPDATA, 34'h00000065);
        kp(`FPKD_K_CLEAR, 1);
        check(disp_value_r, 16'h0065);
        op_u.press(`FPKD_K_VUP, 1250);
        check(disp_value_r >= 16'h006C && disp_value_r <= 16'h006F, 1'b1);
        kp(`FPKD_K_CLEAR, 1);
        check(disp_value_r, 16'h0065);
        op_u.press(`FPKD_K_VUP, 3000);
        check(disp_value_r >= 16'h00A1 && disp_value_r <= 16'h00AE, 1'b1);
        kp(`FPKD_K_CLEAR, 1);
        sp_shown <= 1'b0;
        kp(`FPKD_K_ACT, 1);
        kp(`FPKD_K_VUP, 1);
        check(answer_r, 1'b0);
        q_shown <= 1'b1;
        kp(`FPKD_K_VUP, 1);
        check(answer_r, 1'b1);
        kp(`FPKD_K_VDN, 1);
        check(answer_r, 1'b0);
        kp(`FPKD_K_VUP, 1);
        kp(`FPKD_K_STORE, 1);
        check(n_mt, 1);
        check(flash_code_r, 3'h2);
        q_kind <= 1'b1;
        repeat (2) if (answer_r !== 1'b1) kp(`FPKD_K_VDN, 1);
        kp(`FPKD_K_STORE, 1);
        check(n_st, 1);
        check(flash_code_r, 3'h3);
        out_cond <= 4'h5;
        out_set <= 4'hF;
        @(posedge aclk);
        out_set <= 4'h0;
        repeat (3) @(posedge aclk);
        check(led_r, 4'hF);
        kp(`FPKD_K_RESET, 1);
        check(relay_r, 4'h5);
        check(flash_code_r, 3'h4);
        out_cond <= 4'h0;
        kp(`FPKD_K_RESET, 1);
        check(relay_r, 4'h0);
        check(led_r, 4'h0);
        lk = 8'($urandom);
        lockout_min_in <= lk;
        emerg_pin <= 1'b1;
        repeat (8) @(posedge aclk);
        check(lockout_min_r, 8'h00);
        emerg_pin <= 1'b0;
        repeat (8) @(posedge aclk);
        check(lockout_min_r, lk);
        selftest_fail <= 1'b1;
        tog = 0;
        repeat (3000)
        begin
            pv = service_led_r;
            @(posedge aclk);
            if (service_led_r !== pv)
                tog++;
        end
        check(tog >= 2, 1'b1);
        selftest_fail <= 1'b0;
        low_supply <= 1'b1;
        repeat (10) @(posedge aclk);
        check(service_led_r, 1'b1);
        close_out();
    end
endmodule // tb_top
`default_nettype wire
